// ---- rtl/gwsp_pkg.sv ----
// Shared constants and types for the gain word serial/parallel port.
// Assumes both ends and the bench compile this package first.
package gwsp_pkg;
    localparam int WORD_W      = 9;
    localparam int FINE_LSB    = 0;
    localparam int FINE_W      = 4;
    localparam int COARSE_LSB  = 4;
    localparam int COARSE_W    = 4;
    localparam int ATTEN_BIT   = 8;
    localparam logic [8:0] WORD_RST = 9'h000;
    // Step sizes in tenths of a dB
    localparam int FINE_STEP_TENTHS   = 1;
    localparam int COARSE_STEP_TENTHS = 15;
    localparam int GAIN_W             = 10;
    // Host register map, word offsets on the command port
    localparam logic [1:0] REG_CTRL   = 2'h0;
    localparam logic [1:0] REG_WORD   = 2'h1;
    localparam logic [1:0] REG_STATUS = 2'h2;
    localparam logic [1:0] REG_RDBACK = 2'h3;
    localparam int CTRL_SER_BIT  = 0;
    localparam int CTRL_PDN_BIT  = 1;
    localparam int CMD_WRITE_BIT = 0;
    localparam int CMD_READ_BIT  = 1;
    localparam int SCK_DIV       = 8;
    localparam logic [7:0] SCK_DIV_CNT = 8'h08;
    typedef enum logic [2:0] {GWSP_IDLE, GWSP_LOAD, GWSP_SHIFT_LO, GWSP_SHIFT_HI,
                              GWSP_STROBE, GWSP_DONE} gwsp_state_t;
endpackage

// ---- rtl/gwsp_if.sv ----
// Pin bundle between the gain port and its host.
// Assumes the bench instantiates it and connects both modports.
`timescale 1ns/1ns
`default_nettype none
interface gwsp_if;
    logic interfaceSelect;
    logic shiftClk;
    logic serialGainIn;
    logic latchLoadStrobe;
    logic latchReadbackStrobe;
    logic serialGainOut;
    logic powerDownPin;
    logic attenuateSelect;
    logic [3:0] coarseStepCode;
    logic [3:0] fineStepCode;
    modport dev (input interfaceSelect, shiftClk, serialGainIn, latchLoadStrobe,
                 latchReadbackStrobe, powerDownPin, attenuateSelect, coarseStepCode,
                 fineStepCode, output serialGainOut);
    modport host (output interfaceSelect, shiftClk, serialGainIn, latchLoadStrobe,
                  latchReadbackStrobe, powerDownPin, attenuateSelect, coarseStepCode,
                  fineStepCode, input serialGainOut);
endinterface
`default_nettype wire

// ---- rtl/gwsp_gain_decode.sv ----
// Decodes a 9-bit gain word into a signed gain in tenths of a dB.
// Assumes a stable word from the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module gwsp_gain_decode
(
    input  wire logic [8:0]  gainWord,
    output logic signed [9:0] gainTenths
);
    wire [3:0] fineCode   = gainWord[gwsp_pkg::FINE_LSB +: gwsp_pkg::FINE_W];
    wire [3:0] coarseCode = gainWord[gwsp_pkg::COARSE_LSB +: gwsp_pkg::COARSE_W];
    wire       atten      = gainWord[gwsp_pkg::ATTEN_BIT];
    wire [9:0] fineMag    = 10'(fineCode) * 10'(gwsp_pkg::FINE_STEP_TENTHS);
    wire [9:0] coarseMag  = 10'(coarseCode) * 10'(gwsp_pkg::COARSE_STEP_TENTHS);
    wire [9:0] totalMag   = fineMag + coarseMag;
    assign gainTenths = atten ? -$signed(totalMag) : $signed(totalMag);
endmodule
`default_nettype wire

// ---- rtl/gwsp_device.sv ----
// Device end: shift register, holding latch, readback and mode select.
// Assumes shiftClk is the link clock; strobes change only while it is low.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Select pin high serial, low parallel
// - Shift data in on rising shift clock
// - Load strobe copies shift register to latch
// - Host strobes load only with clock low
// - Shifting never disturbs the latched word
// - Latch sets gain; first bit is bit0
// - Fine code n gives n times 0.1dB
// - Coarse code n gives n times 1.5dB
// - Total is coarse plus fine, signed
// - Readback strobe copies latch to shift register; the code loads it into outReg_q and leaves shiftReg_q alone
// - Host strobes readback only with clock low
// - Output advances on falling shift clock
// - Static logic, no minimum clock rate
// - Parallel mode takes word straight from pins
// - Host drives parallel pins to zero in serial mode
// - Power-down idles output, keeps latch
// - Serial-only variant forces serial mode
module gwsp_device
#(
    parameter bit SERIAL_ONLY = 1'b0
)
(
    gwsp_if.dev                gwspPins,
    input  wire logic          ref_clk,
    input  wire logic          rst_b,
    input  wire logic          clkEn,
    output logic [8:0]         activeWord,
    output logic signed [9:0]  gainTenths,
    output logic               analogOutEnable
);
    logic [8:0] shiftReg_q;
    logic [8:0] latch_q;
    logic       sodOut_q;
    logic [8:0] active_q;
    logic [2:0] selSync_q;
    logic [2:0] pdnSync_q;
    logic [8:0] parWord;
    logic       serialMode;

    // Link-clock side: static register, no free-running assumption
    always_ff @(posedge gwspPins.shiftClk or negedge rst_b)
    begin
        if (!rst_b)
            shiftReg_q <= gwsp_pkg::WORD_RST;
        else
            shiftReg_q <= {gwspPins.serialGainIn, shiftReg_q[8:1]};
    end

    // Load strobe loads on its rising edge; the host keeps shiftClk low meanwhile
    always_ff @(posedge gwspPins.latchLoadStrobe or negedge rst_b)
    begin
        if (!rst_b)
            latch_q <= gwsp_pkg::WORD_RST;
        else
            latch_q <= shiftReg_q;
    end

    // Readback: the shift register image seen at the output, advancing on falls
    logic [8:0] outReg_q;
    always_ff @(negedge gwspPins.shiftClk or posedge gwspPins.latchReadbackStrobe
                or negedge rst_b)
    begin
        if (!rst_b)
        begin
            outReg_q <= gwsp_pkg::WORD_RST;
        end
        else if (gwspPins.latchReadbackStrobe)
        begin
            outReg_q <= latch_q;
        end
        else
        begin
            outReg_q <= {1'b0, outReg_q[8:1]};
        end
    end
    always_comb sodOut_q = outReg_q[0];
    assign gwspPins.serialGainOut = sodOut_q;

    // Latched word crosses into ref_clk: strobes are rare, sample twice and
    // accept only when two samples agree
    logic [8:0] latSync1_q;
    logic [8:0] latSync2_q;
    logic [8:0] latSync3_q;
    logic [8:0] parSync1_q;
    logic [8:0] parSync2_q;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            latSync1_q <= gwsp_pkg::WORD_RST;
            latSync2_q <= gwsp_pkg::WORD_RST;
            latSync3_q <= gwsp_pkg::WORD_RST;
            parSync1_q <= gwsp_pkg::WORD_RST;
            parSync2_q <= gwsp_pkg::WORD_RST;
            selSync_q  <= 3'h0;
            pdnSync_q  <= 3'h0;
            active_q   <= gwsp_pkg::WORD_RST;
        end
        else if (clkEn)
        begin
            latSync1_q <= latch_q;
            latSync2_q <= latSync1_q;
            latSync3_q <= latSync2_q;
            parSync1_q <= parWord;
            parSync2_q <= parSync1_q;
            selSync_q  <= {selSync_q[1:0], gwspPins.interfaceSelect};
            pdnSync_q  <= {pdnSync_q[1:0], gwspPins.powerDownPin};
            active_q   <= serialMode ? ((latSync2_q == latSync3_q) ? latSync3_q : active_q)
                                     : parSync2_q;
        end
    end

    // Parallel pins taken straight from the interface; the host drives them to zero in serial mode
    assign parWord    = {gwspPins.attenuateSelect, gwspPins.coarseStepCode,
                         gwspPins.fineStepCode};
    assign serialMode = SERIAL_ONLY | selSync_q[1];

    assign activeWord      = active_q;
    assign analogOutEnable = ~pdnSync_q[1];

    gwsp_gain_decode u_decode
    (
        .gainWord   (active_q),
        .gainTenths (gainTenths)
    );
endmodule
`default_nettype wire

// ---- rtl/gwsp_host.sv ----
// Host end: drives a gain word serially or in parallel and reads it back.
// Assumes software uses the plain strobe port on ref_clk.
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module gwsp_host
(
    gwsp_if.host         gwspPins,
    input  wire logic    ref_clk,
    input  wire logic    rst_b,
    input  wire logic    clkEn,
    input  wire logic [1:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic    regWrite,
    input  wire logic    regRead,
    output logic [31:0]  regRdata
);
    gwsp_pkg::gwsp_state_t state_q;
    logic [1:0]  ctrl_q;
    logic [8:0]  word_q;
    logic [8:0]  txSh_q;
    logic [8:0]  rx_q;
    logic [3:0]  bitCnt_q;
    logic [7:0]  div_q;
    logic        rdMode_q;
    logic        sck_q;
    logic        sid_q;
    logic        lat_q;
    logic [31:0] rdata_q;
    logic [1:0]  sodSync_q;

    wire busy    = (state_q != gwsp_pkg::GWSP_IDLE);
    wire tick    = (div_q == gwsp_pkg::SCK_DIV_CNT);
    wire wrCtrl  = regWrite && regAddr == gwsp_pkg::REG_CTRL;
    wire wrWord  = regWrite && regAddr == gwsp_pkg::REG_WORD && !busy;
    wire wrCmd   = regWrite && regAddr == gwsp_pkg::REG_STATUS && !busy;
    wire goWrite = wrCmd && regWdata[gwsp_pkg::CMD_WRITE_BIT] && ctrl_q[0];
    wire goRead  = wrCmd && regWdata[gwsp_pkg::CMD_READ_BIT] && ctrl_q[0];
    wire [31:0] rdMux = (regAddr == gwsp_pkg::REG_CTRL)   ? {30'h0, ctrl_q} :
                        (regAddr == gwsp_pkg::REG_WORD)   ? {23'h0, word_q} :
                        (regAddr == gwsp_pkg::REG_STATUS) ? {31'h0, busy} :
                                                            {23'h0, rx_q};

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_q    <= 2'h1;
            word_q    <= gwsp_pkg::WORD_RST;
            rdata_q   <= 32'h0;
            sodSync_q <= 2'h0;
        end
        else if (clkEn)
        begin
            sodSync_q <= {sodSync_q[0], gwspPins.serialGainOut};
            if (wrCtrl)
                ctrl_q <= regWdata[1:0];
            if (wrWord)
                word_q <= regWdata[8:0];
            rdata_q <= regRead ? rdMux : 32'h0;
        end
    end
    assign regRdata = rdata_q;

    // Sequencer: bit 0 first, strobes only while shift clock is low
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q  <= gwsp_pkg::GWSP_IDLE;
            txSh_q   <= gwsp_pkg::WORD_RST;
            rx_q     <= gwsp_pkg::WORD_RST;
            bitCnt_q <= 4'h0;
            div_q    <= 8'h0;
            rdMode_q <= 1'b0;
            sck_q    <= 1'b0;
            sid_q    <= 1'b0;
            lat_q    <= 1'b0;
        end
        else if (clkEn)
        begin
            div_q <= (tick || !busy) ? 8'h0 : div_q + 8'h1;
            unique case (state_q)
                gwsp_pkg::GWSP_IDLE:
                    if (goWrite || goRead)
                    begin
                        txSh_q   <= word_q;
                        sid_q    <= word_q[0];
                        rdMode_q <= goRead;
                        bitCnt_q <= 4'h0;
                        state_q  <= goRead ? gwsp_pkg::GWSP_LOAD : gwsp_pkg::GWSP_SHIFT_LO;
                        lat_q    <= goRead;
                    end
                gwsp_pkg::GWSP_LOAD:
                    if (tick)
                    begin
                        lat_q   <= 1'b0;
                        state_q <= gwsp_pkg::GWSP_SHIFT_LO;
                    end
                gwsp_pkg::GWSP_SHIFT_LO:
                    if (tick)
                    begin
                        // Data already stands for the whole low phase: setup before the rise
                        sck_q   <= 1'b1;
                        if (rdMode_q)
                            rx_q <= {sodSync_q[1], rx_q[8:1]};
                        state_q <= gwsp_pkg::GWSP_SHIFT_HI;
                    end
                gwsp_pkg::GWSP_SHIFT_HI:
                    if (tick)
                    begin
                        sck_q    <= 1'b0;
                        sid_q    <= txSh_q[1];
                        txSh_q   <= {1'b0, txSh_q[8:1]};
                        bitCnt_q <= bitCnt_q + 4'h1;
                        if (bitCnt_q == 4'(gwsp_pkg::WORD_W - 1))
                            state_q <= rdMode_q ? gwsp_pkg::GWSP_DONE : gwsp_pkg::GWSP_STROBE;
                        else
                            state_q <= gwsp_pkg::GWSP_SHIFT_LO;
                    end
                gwsp_pkg::GWSP_STROBE:
                    if (tick)
                    begin
                        lat_q   <= ~lat_q;
                        state_q <= lat_q ? gwsp_pkg::GWSP_DONE : gwsp_pkg::GWSP_STROBE;
                    end
                gwsp_pkg::GWSP_DONE:
                    state_q <= gwsp_pkg::GWSP_IDLE;
                default:
                    state_q <= gwsp_pkg::GWSP_IDLE;
            endcase
        end
    end

    assign gwspPins.interfaceSelect     = ctrl_q[gwsp_pkg::CTRL_SER_BIT];
    assign gwspPins.powerDownPin        = ctrl_q[gwsp_pkg::CTRL_PDN_BIT];
    assign gwspPins.shiftClk            = sck_q;
    assign gwspPins.serialGainIn        = sid_q;
    assign gwspPins.latchLoadStrobe     = lat_q && !rdMode_q;
    assign gwspPins.latchReadbackStrobe = lat_q && rdMode_q;
    assign gwspPins.attenuateSelect     = ctrl_q[0] ? 1'b0 : word_q[gwsp_pkg::ATTEN_BIT];
    assign gwspPins.coarseStepCode      = ctrl_q[0] ? 4'h0 : word_q[7:4];
    assign gwspPins.fineStepCode        = ctrl_q[0] ? 4'h0 : word_q[3:0];
endmodule
`default_nettype wire

// ---- verification/gwsp_link_sva.sv ----
// Checker on the pin bundle between the gain port host and device ends.
// Assumes ref_clk samples every pin and both ends run on it.
`timescale 1ns/1ns
`default_nettype none
module gwsp_link_sva
(
    input wire logic       ref_clk,
    input wire logic       rst_b,
    input wire logic       interfaceSelect,
    input wire logic       shiftClk,
    input wire logic       serialGainIn,
    input wire logic       latchLoadStrobe,
    input wire logic       latchReadbackStrobe,
    input wire logic       serialGainOut,
    input wire logic       powerDownPin,
    input wire logic       attenuateSelect,
    input wire logic [3:0] coarseStepCode,
    input wire logic [3:0] fineStepCode
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    AST_LOAD_SCK_LOW: assert property (latchLoadStrobe |-> !shiftClk)
        else $error("load strobe with shift clock high");
    AST_RDBK_SCK_LOW: assert property (latchReadbackStrobe |-> !shiftClk)
        else $error("readback strobe with shift clock high");
    AST_STROBES_APART: assert property (!(latchLoadStrobe && latchReadbackStrobe))
        else $error("both strobes high");
    AST_SCK_HALF: assert property ($rose(shiftClk) |-> ##8 shiftClk ##1 !shiftClk)
        else $error("shift clock high phase length wrong");
    AST_SID_HOLD: assert property (shiftClk && $past(shiftClk) |-> $stable(serialGainIn))
        else $error("serial input moved while shift clock high");
    AST_SOD_ON_LOW: assert property ($changed(serialGainOut) |-> !shiftClk)
        else $error("serial output moved while shift clock high");
    AST_PAR_QUIET: assert property (!interfaceSelect |-> !latchLoadStrobe
        && !latchReadbackStrobe && !shiftClk)
        else $error("serial activity in parallel mode");
    AST_SER_PINS_ZERO: assert property (interfaceSelect |-> !attenuateSelect
        && coarseStepCode == 4'h0 && fineStepCode == 4'h0)
        else $error("parallel pins driven in serial mode");
    COV_LOAD: cover property ($rose(latchLoadStrobe));
    COV_RDBK: cover property ($rose(latchReadbackStrobe));
    COV_PAR: cover property ($fell(interfaceSelect));
    COV_PDN: cover property ($rose(powerDownPin) && interfaceSelect);
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Bench joining host and device ends; drives the host command port.
// Assumes the rtl package, interface and both ends are compiled first.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        ref_clk;
    logic        rst_b;
    logic [1:0]  regAddr;
    logic [31:0] regWdata;
    logic        regWrite;
    logic        regRead;
    logic [31:0] regRdata;
    logic [8:0]  activeWord;
    logic signed [9:0] gainTenths;
    logic        analogOutEnable;
    logic [8:0]  sidCap;
    logic [8:0]  sodCap;
    logic        sckD;
    logic        sidD;
    logic [31:0] rd;
    logic [8:0]  words [5];
    int          error_cnt;
    int          tests_run;
    int          cycles;
    gwsp_if gwspPins ();
    gwsp_host u_gwsp_host (.gwspPins(gwspPins.host), .ref_clk(ref_clk), .rst_b(rst_b),
        .clkEn(1'b1), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata));
    gwsp_device u_gwsp_device (.gwspPins(gwspPins.dev), .ref_clk(ref_clk), .rst_b(rst_b),
        .clkEn(1'b1), .activeWord(activeWord), .gainTenths(gainTenths),
        .analogOutEnable(analogOutEnable));
    gwsp_link_sva u_gwsp_link_sva (.ref_clk(ref_clk), .rst_b(rst_b),
        .interfaceSelect(gwspPins.interfaceSelect), .shiftClk(gwspPins.shiftClk),
        .serialGainIn(gwspPins.serialGainIn), .latchLoadStrobe(gwspPins.latchLoadStrobe),
        .latchReadbackStrobe(gwspPins.latchReadbackStrobe),
        .serialGainOut(gwspPins.serialGainOut), .powerDownPin(gwspPins.powerDownPin),
        .attenuateSelect(gwspPins.attenuateSelect),
        .coarseStepCode(gwspPins.coarseStepCode), .fineStepCode(gwspPins.fineStepCode));
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // Wire bits as they stood just before each rising shift clock
    always @(posedge ref_clk)
    begin
        sckD <= gwspPins.shiftClk;
        sidD <= gwspPins.serialGainIn;
        if (gwspPins.shiftClk && !sckD)
        begin
            sidCap <= {sidD, sidCap[8:1]};
            sodCap <= {gwspPins.serialGainOut, sodCap[8:1]};
        end
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            error_cnt++;
            final_report();
        end
    end
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Called just after a rising edge; returns just after a rising edge
    task automatic regWr(input logic [1:0] a, input logic [31:0] d);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic regRd(input logic [1:0] a, output logic [31:0] d);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 d = regRdata;
        @(posedge ref_clk);
    endtask
    task automatic command(input logic [31:0] c);
        logic [31:0] s;
        regWr(gwsp_pkg::REG_STATUS, c);
        s = 32'h1;
        for (int i = 0; i < 1000 && s[0] !== 1'b0; i++)
            regRd(gwsp_pkg::REG_STATUS, s);
        chk("busy", s, 32'h0);
        repeat (8) @(posedge ref_clk);
    endtask
    function automatic logic signed [9:0] expGain(input logic [8:0] w);
        int mag;
        mag = w[7:4] * gwsp_pkg::COARSE_STEP_TENTHS + w[3:0] * gwsp_pkg::FINE_STEP_TENTHS;
        return w[8] ? 10'(-mag) : 10'(mag);
    endfunction
    task automatic settle();
        repeat (8) @(posedge ref_clk);
    endtask
    initial
    begin
        words = '{9'h1ff, 9'h0ff, 9'h15a, 9'h0a5, 9'h100};
        {rst_b, regAddr, regWdata, regWrite, regRead, cycles, error_cnt, tests_run} = '0;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        settle();
        chk("activeWord", 32'(activeWord), 32'h0);
        chk("outEnable", 32'(analogOutEnable), 32'h1);
        regRd(gwsp_pkg::REG_CTRL, rd);
        chk("ctrl", rd, 32'h1);
        $display("Test reset done");
        foreach (words[i])
        begin
            regWr(gwsp_pkg::REG_WORD, 32'(words[i]));
            command(32'h1);
            chk("activeWord", 32'(activeWord), 32'(words[i]));
            chk("gain", 32'(gainTenths), 32'(expGain(words[i])));
            chk("wireIn", 32'(sidCap), 32'(words[i]));
            command(32'h2);
            regRd(gwsp_pkg::REG_RDBACK, rd);
            chk("readback", rd, 32'(words[i]));
            chk("wireOut", 32'(sodCap), 32'(words[i]));
            chk("heldWord", 32'(activeWord), 32'(words[i]));
        end
        $display("Test serial done");
        regWr(gwsp_pkg::REG_WORD, 32'h0c3);
        regWr(gwsp_pkg::REG_CTRL, 32'h0);
        settle();
        chk("parWord", 32'(activeWord), 32'h0c3);
        chk("parGain", 32'(gainTenths), 32'(expGain(9'h0c3)));
        regWr(gwsp_pkg::REG_CTRL, 32'h1);
        settle();
        chk("serWord", 32'(activeWord), 32'h100);
        $display("Test parallel done");
        regWr(gwsp_pkg::REG_CTRL, 32'h3);
        settle();
        chk("outEnable", 32'(analogOutEnable), 32'h0);
        chk("pdnWord", 32'(activeWord), 32'h100);
        regWr(gwsp_pkg::REG_WORD, 32'h07e);
        command(32'h1);
        chk("pdnLoad", 32'(activeWord), 32'h07e);
        chk("pdnGain", 32'(gainTenths), 32'(expGain(9'h07e)));
        regWr(gwsp_pkg::REG_CTRL, 32'h1);
        settle();
        chk("outEnable", 32'(analogOutEnable), 32'h1);
        $display("Test power-down done");
        final_report();
    end
endmodule
`default_nettype wire
